// ==== hdl/ofcr_pkg.sv ====
package ofcr_pkg;

  // Internal register address: page in bits 9:8, serial pointer in bits 7:0
  localparam int          ADDR_W                   = 10;
  localparam int          PAGE_W                   = 2;
  localparam int          PTR_W                    = 8;

  localparam logic [9:0]  PART_ID_ADDR             = 10'h000;
  localparam logic [9:0]  SOFT_RESET_CAL_ADDR      = 10'h007;
  localparam logic [9:0]  OUTPUT_CLOCK_GATE_ADDR   = 10'h011;
  localparam logic [9:0]  HS_DIVIDER_LOW_ADDR      = 10'h017;
  localparam logic [9:0]  HS_DIVIDER_HIGH_ADDR     = 10'h018;
  localparam logic [9:0]  FEEDBACK_BYTE0_ADDR      = 10'h01a;
  localparam logic [9:0]  FEEDBACK_BYTE1_ADDR      = 10'h01b;
  localparam logic [9:0]  FEEDBACK_BYTE2_ADDR      = 10'h01c;
  localparam logic [9:0]  FEEDBACK_BYTE3_ADDR      = 10'h01d;
  localparam logic [9:0]  FEEDBACK_BYTE4_ADDR      = 10'h01e;
  localparam logic [9:0]  FEEDBACK_BYTE5_ADDR      = 10'h01f;
  localparam logic [9:0]  CAL_BYPASS_CTRL_ADDR     = 10'h045;
  localparam logic [9:0]  FINE_OFFSET_BYTE0_ADDR   = 10'h0e7;
  localparam logic [9:0]  FINE_OFFSET_BYTE1_ADDR   = 10'h0e8;
  localparam logic [9:0]  FINE_OFFSET_BYTE2_ADDR   = 10'h0e9;
  // Page register answers at this pointer on every page
  localparam logic [7:0]  PAGE_SELECT_PTR          = 8'hff;

  // Field positions
  localparam int          SOFT_RESET_BIT           = 7;
  localparam int          CAL_START_BIT            = 3;
  localparam int          OUTPUT_CLOCK_ENABLE_BIT  = 0;
  localparam int          HS_HIGH_MSB              = 2;
  localparam int          POW2_LSB                 = 4;
  localparam int          POW2_MSB                 = 6;
  localparam int          CAL_BYPASS_BIT           = 7;
  localparam logic [6:0]  CAL_BYPASS_RESERVED      = 7'h01;

  // Reset values
  localparam logic        OUTPUT_CLOCK_EN_RESET    = 1'b1;
  localparam logic [10:0] HS_DIVIDER_RESET         = 11'h054;
  localparam logic [2:0]  POW2_DIVIDER_RESET       = 3'h0;
  localparam logic [42:0] FEEDBACK_RESET           = 43'h064_0000_0000;
  localparam logic        CAL_BYPASS_RESET         = 1'b0;
  localparam logic [23:0] FINE_OFFSET_RESET        = 24'h00_0000;
  localparam logic [1:0]  PAGE_RESET               = 2'h0;

  // Power-of-two divider: codes at or above the clip code divide by the maximum
  localparam logic [2:0]  POW2_CLIP_CODE           = 3'h5;
  localparam logic [5:0]  POW2_MAX_RATIO           = 6'h20;
  localparam logic [5:0]  POW2_UNIT_RATIO          = 6'h01;

  // Two-wire serial constants
  localparam logic [2:0]  LAST_BIT                 = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WRITE,
    ST_WRITE_ACK,
    ST_READ,
    ST_READ_ACK
  } ofcr_state_type;

endpackage

// ==== hdl/ofcr_sync2.sv ====
`timescale 1ns/100ps
module ofcr_sync2 (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // Asynchronous level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_reg <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ==== hdl/ofcr_regs.sv ====
`timescale 1ns/100ps
// Overview of operation
// R1: Register 0 returns a fixed 8-bit part code; writes are ignored.
// R2: Writing 1 to register 7 bit 7 resets the device; bit self-clears.
// R3: Writing 1 to register 7 bit 3 starts calibration; bit self-clears.
// R4: Register 17 bit 0 gates the output clock: 0 stops, 1 runs.
// R5: 11-bit high-speed divider: low byte register 23, top three bits register 24.
// R6: Host keeps high-speed divider 5..2046, odd values only up to 33.
// R7: Power-of-two code 0..7 divides by 1,2,4,8,16,32,32,32.
// R8: Power-of-two code 0 passes the signal through undivided.
// R9: 43-bit 11.32 feedback divider across registers 26 to 31.
// R10: Host keeps feedback divider integer part within 60..2045.
// R11: Register 69 bit 7 set skips calibration; clear allows it.
// R12: 24-bit two's complement fine offset in registers 231 to 233.
// R13: Host keeps fine offset within -8161513..+8161512.
// R14: Fine offset takes effect only when register 233 is written.
// R15: Host writes fine offset bytes 231, 232, then 233.
// R16: 2-bit page in register 255 selects the 256-byte register page.
// R17: Internal address is page times 256 plus serial pointer.
module ofcr_regs #(
  parameter logic [6:0] DEVICE_ADDR = 7'h55, // Arbitrary bus address
  parameter logic [7:0] PART_ID     = 8'h5a  // Arbitrary part code
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // Two-wire serial pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  // Oscillator controls
  output logic             output_clock_enable_out,
  output logic [10:0]      high_speed_divider_out,
  output logic [2:0]       power_of_two_divider_out,
  output logic [5:0]       power_of_two_ratio_out,
  output logic [42:0]      feedback_divider_ratio_out,
  output logic             calibration_bypass_out,
  output logic [23:0]      fine_frequency_offset_out,
  output logic [1:0]       page_out,
  // Event pulses
  output logic             soft_reset_out,
  output logic             calibration_start_out
);

  logic                    scl_sync;
  logic                    sda_sync;
  logic                    scl_prev_reg;
  logic                    sda_prev_reg;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_seen;
  logic                    stop_seen;

  ofcr_pkg::ofcr_state_type state_reg;
  logic [2:0]              bit_cnt_reg;
  logic [7:0]              shift_reg;
  logic [7:0]              ptr_reg;
  logic                    byte_full_reg;
  logic                    first_byte_reg;
  logic                    read_mode_reg;
  logic                    acked_reg;

  logic                    wr_strobe;
  logic [9:0]              access_addr;
  logic [7:0]              read_data;
  logic                    soft_reset_hit;

  logic [7:0]              fine_offset_byte0_reg;
  logic [7:0]              fine_offset_byte1_reg;

  ofcr_sync2 scl_sync_inst (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (scl_in),
    .sync_out (scl_sync)
  );

  ofcr_sync2 sda_sync_inst (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (sda_in),
    .sync_out (sda_sync)
  );

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_sync;
      sda_prev_reg <= sda_sync;
    end
  end

  assign scl_rise   = scl_sync & ~scl_prev_reg;
  assign scl_fall   = ~scl_sync & scl_prev_reg;
  assign start_seen = scl_sync & scl_prev_reg & sda_prev_reg & ~sda_sync;
  assign stop_seen  = scl_sync & scl_prev_reg & ~sda_prev_reg & sda_sync;

  // Page bits on top of the serial pointer
  assign access_addr = {page_out, ptr_reg}; // R17 R16

  // Serial slave: first written byte loads the pointer, later bytes auto-increment
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_reg      <= ofcr_pkg::ST_IDLE;
      bit_cnt_reg    <= 3'h0;
      shift_reg      <= 8'h00;
      ptr_reg        <= 8'h00;
      byte_full_reg  <= 1'b0;
      first_byte_reg <= 1'b0;
      read_mode_reg  <= 1'b0;
      acked_reg      <= 1'b0;
      sda_oe_out     <= 1'b0;
    end else if (start_seen) begin
      state_reg     <= ofcr_pkg::ST_ADDR;
      bit_cnt_reg   <= 3'h0;
      byte_full_reg <= 1'b0;
      sda_oe_out    <= 1'b0;
    end else if (stop_seen) begin
      state_reg  <= ofcr_pkg::ST_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      unique case (state_reg)
        ofcr_pkg::ST_IDLE: begin
          sda_oe_out <= 1'b0;
        end
        ofcr_pkg::ST_ADDR, ofcr_pkg::ST_WRITE: begin
          if (scl_rise) begin
            shift_reg     <= {shift_reg[6:0], sda_sync};
            bit_cnt_reg   <= bit_cnt_reg + 3'h1;
            byte_full_reg <= (bit_cnt_reg == ofcr_pkg::LAST_BIT);
          end else if (scl_fall && byte_full_reg) begin
            byte_full_reg <= 1'b0;
            if (state_reg == ofcr_pkg::ST_ADDR) begin
              if (shift_reg[7:1] == DEVICE_ADDR) begin
                sda_oe_out     <= 1'b1;
                read_mode_reg  <= shift_reg[0];
                first_byte_reg <= ~shift_reg[0];
                state_reg      <= ofcr_pkg::ST_ADDR_ACK;
              end else begin
                state_reg <= ofcr_pkg::ST_IDLE;
              end
            end else begin
              sda_oe_out     <= 1'b1;
              first_byte_reg <= 1'b0;
              state_reg      <= ofcr_pkg::ST_WRITE_ACK;
              if (first_byte_reg) begin
                ptr_reg <= shift_reg;
              end else begin
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
        end
        ofcr_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (read_mode_reg) begin
              shift_reg   <= read_data;
              sda_oe_out  <= ~read_data[7];
              ptr_reg     <= ptr_reg + 8'h01;
              bit_cnt_reg <= 3'h0;
              state_reg   <= ofcr_pkg::ST_READ;
            end else begin
              sda_oe_out <= 1'b0;
              state_reg  <= ofcr_pkg::ST_WRITE;
            end
          end
        end
        ofcr_pkg::ST_WRITE_ACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            state_reg  <= ofcr_pkg::ST_WRITE;
          end
        end
        ofcr_pkg::ST_READ: begin
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == ofcr_pkg::LAST_BIT) begin
              sda_oe_out <= 1'b0;
              state_reg  <= ofcr_pkg::ST_READ_ACK;
            end else begin
              shift_reg  <= {shift_reg[6:0], 1'b0};
              sda_oe_out <= ~shift_reg[6];
            end
          end
        end
        ofcr_pkg::ST_READ_ACK: begin
          if (scl_rise) begin
            acked_reg <= ~sda_sync;
          end else if (scl_fall) begin
            if (acked_reg) begin
              shift_reg   <= read_data;
              sda_oe_out  <= ~read_data[7];
              ptr_reg     <= ptr_reg + 8'h01;
              bit_cnt_reg <= 3'h0;
              state_reg   <= ofcr_pkg::ST_READ;
            end else begin
              state_reg <= ofcr_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Open-drain: the pin is only ever pulled low
  always_ff @(posedge clk_in) begin
    sda_out <= 1'b0;
  end

  assign wr_strobe = (state_reg == ofcr_pkg::ST_WRITE) && scl_fall && byte_full_reg && !first_byte_reg
                     && !start_seen && !stop_seen;
  assign soft_reset_hit = wr_strobe && (access_addr == ofcr_pkg::SOFT_RESET_CAL_ADDR)
                          && shift_reg[ofcr_pkg::SOFT_RESET_BIT];

  // Register file; soft reset returns every field to its default
  always_ff @(posedge clk_in) begin
    if (reset_in || soft_reset_hit) begin // R2
      output_clock_enable_out    <= ofcr_pkg::OUTPUT_CLOCK_EN_RESET;
      high_speed_divider_out     <= ofcr_pkg::HS_DIVIDER_RESET;
      power_of_two_divider_out   <= ofcr_pkg::POW2_DIVIDER_RESET;
      feedback_divider_ratio_out <= ofcr_pkg::FEEDBACK_RESET;
      calibration_bypass_out     <= ofcr_pkg::CAL_BYPASS_RESET;
      fine_offset_byte0_reg      <= ofcr_pkg::FINE_OFFSET_RESET[7:0];
      fine_offset_byte1_reg      <= ofcr_pkg::FINE_OFFSET_RESET[15:8];
      fine_frequency_offset_out  <= ofcr_pkg::FINE_OFFSET_RESET;
      page_out                   <= ofcr_pkg::PAGE_RESET;
    end else if (wr_strobe) begin
      if (ptr_reg == ofcr_pkg::PAGE_SELECT_PTR) begin
        page_out <= shift_reg[ofcr_pkg::PAGE_W-1:0]; // R16
      end
      unique case (access_addr)
        ofcr_pkg::OUTPUT_CLOCK_GATE_ADDR:
          output_clock_enable_out <= shift_reg[ofcr_pkg::OUTPUT_CLOCK_ENABLE_BIT]; // R4
        ofcr_pkg::HS_DIVIDER_LOW_ADDR:
          high_speed_divider_out[7:0] <= shift_reg; // R5
        ofcr_pkg::HS_DIVIDER_HIGH_ADDR: begin
          high_speed_divider_out[10:8] <= shift_reg[ofcr_pkg::HS_HIGH_MSB:0]; // R5
          power_of_two_divider_out     <= shift_reg[ofcr_pkg::POW2_MSB:ofcr_pkg::POW2_LSB];
        end
        ofcr_pkg::FEEDBACK_BYTE0_ADDR: feedback_divider_ratio_out[7:0]   <= shift_reg; // R9
        ofcr_pkg::FEEDBACK_BYTE1_ADDR: feedback_divider_ratio_out[15:8]  <= shift_reg; // R9
        ofcr_pkg::FEEDBACK_BYTE2_ADDR: feedback_divider_ratio_out[23:16] <= shift_reg; // R9
        ofcr_pkg::FEEDBACK_BYTE3_ADDR: feedback_divider_ratio_out[31:24] <= shift_reg; // R9
        ofcr_pkg::FEEDBACK_BYTE4_ADDR: feedback_divider_ratio_out[39:32] <= shift_reg; // R9
        ofcr_pkg::FEEDBACK_BYTE5_ADDR: feedback_divider_ratio_out[42:40] <= shift_reg[2:0]; // R9
        ofcr_pkg::CAL_BYPASS_CTRL_ADDR:
          calibration_bypass_out <= shift_reg[ofcr_pkg::CAL_BYPASS_BIT]; // R11
        ofcr_pkg::FINE_OFFSET_BYTE0_ADDR: fine_offset_byte0_reg <= shift_reg; // R14
        ofcr_pkg::FINE_OFFSET_BYTE1_ADDR: fine_offset_byte1_reg <= shift_reg; // R14
        ofcr_pkg::FINE_OFFSET_BYTE2_ADDR:
          fine_frequency_offset_out <= {shift_reg, fine_offset_byte1_reg, fine_offset_byte0_reg}; // R12 R14
        default: begin
        end
      endcase
    end
  end

  // Self-clearing triggers appear only as one-cycle pulses
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      soft_reset_out        <= 1'b0;
      calibration_start_out <= 1'b0;
    end else begin
      soft_reset_out        <= soft_reset_hit; // R2
      calibration_start_out <= wr_strobe && !soft_reset_hit && !calibration_bypass_out
                               && (access_addr == ofcr_pkg::SOFT_RESET_CAL_ADDR)
                               && shift_reg[ofcr_pkg::CAL_START_BIT]; // R3 R11
    end
  end

  // Divide ratio of the power-of-two stage; code 0 is a pass-through
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      power_of_two_ratio_out <= ofcr_pkg::POW2_UNIT_RATIO;
    end else if (power_of_two_divider_out >= ofcr_pkg::POW2_CLIP_CODE) begin
      power_of_two_ratio_out <= ofcr_pkg::POW2_MAX_RATIO; // R7
    end else begin
      power_of_two_ratio_out <= ofcr_pkg::POW2_UNIT_RATIO << power_of_two_divider_out; // R7 R8
    end
  end

  // Read-back; triggers read as zero, unmapped addresses read zero
  always_comb begin
    read_data = 8'h00;
    if (ptr_reg == ofcr_pkg::PAGE_SELECT_PTR) begin
      read_data = {6'h00, page_out};
    end else begin
      unique case (access_addr)
        ofcr_pkg::PART_ID_ADDR:           read_data = PART_ID; // R1
        ofcr_pkg::OUTPUT_CLOCK_GATE_ADDR: read_data = {7'h00, output_clock_enable_out};
        ofcr_pkg::HS_DIVIDER_LOW_ADDR:    read_data = high_speed_divider_out[7:0];
        ofcr_pkg::HS_DIVIDER_HIGH_ADDR:
          read_data = {1'b0, power_of_two_divider_out, 1'b0, high_speed_divider_out[10:8]};
        ofcr_pkg::FEEDBACK_BYTE0_ADDR:    read_data = feedback_divider_ratio_out[7:0];
        ofcr_pkg::FEEDBACK_BYTE1_ADDR:    read_data = feedback_divider_ratio_out[15:8];
        ofcr_pkg::FEEDBACK_BYTE2_ADDR:    read_data = feedback_divider_ratio_out[23:16];
        ofcr_pkg::FEEDBACK_BYTE3_ADDR:    read_data = feedback_divider_ratio_out[31:24];
        ofcr_pkg::FEEDBACK_BYTE4_ADDR:    read_data = feedback_divider_ratio_out[39:32];
        ofcr_pkg::FEEDBACK_BYTE5_ADDR:    read_data = {5'h00, feedback_divider_ratio_out[42:40]};
        ofcr_pkg::CAL_BYPASS_CTRL_ADDR:
          read_data = {calibration_bypass_out, ofcr_pkg::CAL_BYPASS_RESERVED};
        ofcr_pkg::FINE_OFFSET_BYTE0_ADDR: read_data = fine_offset_byte0_reg;
        ofcr_pkg::FINE_OFFSET_BYTE1_ADDR: read_data = fine_offset_byte1_reg;
        ofcr_pkg::FINE_OFFSET_BYTE2_ADDR: read_data = fine_frequency_offset_out[23:16];
        default:                          read_data = 8'h00;
      endcase
    end
  end

endmodule

// ==== dv/ofcr_regs_chk.sv ====
`timescale 1ns/100ps
module ofcr_regs_chk (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        reset_in,
  // Serial pins
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_out,
  // Oscillator controls
  input wire logic        output_clock_enable_out,
  input wire logic [10:0] high_speed_divider_out,
  input wire logic [2:0]  power_of_two_divider_out,
  input wire logic [5:0]  power_of_two_ratio_out,
  input wire logic [42:0] feedback_divider_ratio_out,
  input wire logic        calibration_bypass_out,
  input wire logic [23:0] fine_frequency_offset_out,
  input wire logic [1:0]  page_out,
  // Event pulses
  input wire logic        soft_reset_out,
  input wire logic        calibration_start_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  function automatic logic [5:0] ratio_of(input logic [2:0] c);
    return (c > 3'h5) ? 6'h20 : (6'h01 << c);
  endfunction

  sequence pulse_s(logic x);
    x ##1 !x;
  endsequence
  sequence defaults_s;
    output_clock_enable_out && high_speed_divider_out == 11'h054 && power_of_two_divider_out == 3'h0 &&
    feedback_divider_ratio_out == 43'h064_0000_0000 && !calibration_bypass_out &&
    fine_frequency_offset_out == 24'h00_0000 && page_out == 2'h0;
  endsequence
  // Register updates land at a byte's closing fall, while the device acknowledges
  sequence acked_s;
    !scl_in ##[0:2] sda_oe_out;
  endsequence

  pow2_ratio_map_a: assert property (
    power_of_two_ratio_out == ratio_of($past(power_of_two_divider_out)))
    else $error("power-of-two ratio does not match code");
  pow2_bypass_a: assert property (
    power_of_two_divider_out == 3'h0 |=> power_of_two_ratio_out == 6'h01)
    else $error("code zero does not divide by one");
  soft_pulse_a: assert property (soft_reset_out |-> pulse_s(soft_reset_out))
    else $error("soft reset pulse not one cycle");
  soft_defaults_a: assert property (soft_reset_out |-> ##2 defaults_s)
    else $error("soft reset did not restore defaults");
  cal_pulse_a: assert property (
    calibration_start_out |-> (!calibration_bypass_out && !soft_reset_out) ##1 !calibration_start_out)
    else $error("calibration start pulse wrong");
  cfg_with_ack_a: assert property (
    $changed({output_clock_enable_out, high_speed_divider_out, power_of_two_divider_out,
              feedback_divider_ratio_out, calibration_bypass_out}) |-> acked_s)
    else $error("configuration changed outside a byte write");
  offset_commit_a: assert property ($changed(fine_frequency_offset_out) |-> acked_s)
    else $error("fine offset changed outside a byte write");
  page_update_a: assert property ($changed(page_out) |-> acked_s)
    else $error("page changed outside a byte write");
endmodule

// ==== dv/ofcr_host_model.sv ====
`timescale 1ns/100ps
module ofcr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h55
) (
  input  wire logic clk_in,
  input  wire logic sda_wire_in,
  output logic      scl_out = 1'b1,
  output logic      sda_low_out = 1'b0
);
  int n_nak = 0;

  task automatic half();
    repeat (6) @(negedge clk_in);
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_low_out = 1'b1;
    half();
    scl_out = 1'b0;
    half();
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_low_out = 1'b0;
    half();
  endtask
  task automatic bit_io(input logic b, output logic got);
    sda_low_out = !b;
    half();
    scl_out = 1'b1;
    half();
    got = sda_wire_in;
    scl_out = 1'b0;
    half();
  endtask
  // Ninth bit is always released: device ACK on writes, host NACK on reads
  task automatic byte_io(input logic [7:0] tx, input logic want_ack, output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, a);
    if (want_ack && a) n_nak++;
  endtask
  task automatic wr_n(input logic [7:0] ptr, input logic [47:0] d, input int n);
    logic [7:0] r;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, r);
    byte_io(ptr, 1'b1, r);
    for (int i = 0; i < n; i++) byte_io(d[i*8 +: 8], 1'b1, r);
    stop();
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    wr_n(ptr, {40'h0, d}, 1);
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] r;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, r);
    byte_io(ptr, 1'b1, r);
    start();
    byte_io({DEV_ADDR, 1'b1}, 1'b1, r);
    byte_io(8'hff, 1'b0, d);
    stop();
  endtask
  // Two-byte read: host acknowledges the first byte, refuses the second
  task automatic rd2(input logic [7:0] ptr, output logic [15:0] d);
    logic [7:0] r;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, r);
    byte_io(ptr, 1'b1, r);
    start();
    byte_io({DEV_ADDR, 1'b1}, 1'b1, r);
    for (int i = 15; i >= 8; i--) bit_io(1'b1, d[i]);
    bit_io(1'b0, r[0]);
    byte_io(8'hff, 1'b0, d[7:0]);
    stop();
  endtask
  task automatic wr_offset(input logic [23:0] v);
    wr(8'he7, v[7:0]);
    wr(8'he8, v[15:8]);
    wr(8'he9, v[23:16]);
  endtask
endmodule

// ==== dv/ofcr_regs_test.sv ====
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module ofcr_regs_test;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary part code
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        scl, sda_low, sda_out, sda_oe_out, clk_en, bypass, soft_p, cal_p;
  logic        sda_wire;
  logic [10:0] hs;
  logic [2:0]  p2;
  logic [5:0]  ratio;
  logic [42:0] fb;
  logic [23:0] offs;
  logic [1:0]  page;
  logic [7:0]  rd;
  logic [15:0] rd16;
  int          failures = 0, n_tests = 0, n_soft = 0, n_cal = 0;

  // Open-drain line with pull-up
  assign sda_wire = !(sda_low || (sda_oe_out && !sda_out));
  always #5 clk_in = ~clk_in;
  // Unknown pulse levels count as events so they cannot hide
  always @(posedge clk_in) begin
    if (!reset_in && soft_p !== 1'b0) n_soft++;
    if (!reset_in && cal_p !== 1'b0) n_cal++;
  end

  ofcr_host_model host_u (.clk_in(clk_in), .sda_wire_in(sda_wire), .scl_out(scl), .sda_low_out(sda_low));
  ofcr_regs #(.PART_ID(ID)) dut_u (
    .clk_in(clk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .output_clock_enable_out(clk_en), .high_speed_divider_out(hs),
    .power_of_two_divider_out(p2), .power_of_two_ratio_out(ratio), .feedback_divider_ratio_out(fb),
    .calibration_bypass_out(bypass), .fine_frequency_offset_out(offs), .page_out(page),
    .soft_reset_out(soft_p), .calibration_start_out(cal_p));

  task automatic t_ident();
    `CHK("clk_en", 1'b1, clk_en)
    `CHK("hs_div", 11'h054, hs)
    `CHK("ratio", 6'h01, ratio)
    `CHK("fb_div", 43'h064_0000_0000, fb)
    host_u.rd(8'h00, rd);
    `CHK("part_id", ID, rd)
    host_u.wr(8'h00, 8'h00);
    host_u.rd(8'h00, rd);
    `CHK("part_id_wr", ID, rd)
  endtask
  task automatic t_dividers();
    host_u.wr(8'h17, 8'hfe);
    for (int c = 0; c < 8; c++) begin
      host_u.wr(8'h18, 8'h8f | (c[7:0] << 4));
      `CHK("pow2", c[2:0], p2)
      `CHK("ratio", (c > 4) ? 6'h20 : (6'h01 << c), ratio)
      `CHK("hs_div", 11'h7fe, hs)
    end
    host_u.rd(8'h18, rd);
    `CHK("reg24", 8'h77, rd)
  endtask
  task automatic t_feedback();
    host_u.wr_n(8'h1a, 48'h07_fd_89_ab_cd_ef, 6);
    `CHK("fb_div", 43'h7fd_89ab_cdef, fb)
    host_u.rd2(8'h1e, rd16);
    `CHK("fb_rd", 16'hfd07, rd16)
  endtask
  task automatic t_clock_bypass();
    host_u.wr(8'h11, 8'h00);
    `CHK("clk_en", 1'b0, clk_en)
    host_u.wr(8'h11, 8'h01);
    `CHK("clk_en", 1'b1, clk_en)
    host_u.wr(8'h45, 8'h81);
    `CHK("bypass", 1'b1, bypass)
    host_u.rd(8'h45, rd);
    `CHK("reg69", 8'h81, rd)
    host_u.wr(8'h07, 8'h08);
    `CHK("cal_cnt", 0, n_cal)
    host_u.wr(8'h45, 8'h01);
    `CHK("bypass", 1'b0, bypass)
    host_u.wr(8'h07, 8'h08);
    `CHK("cal_cnt", 1, n_cal)
    host_u.rd(8'h07, rd);
    `CHK("reg7", 8'h00, rd)
  endtask
  task automatic t_fine_offset();
    host_u.wr(8'he7, 8'h17);
    host_u.wr(8'he8, 8'h77);
    `CHK("offset_held", 24'h00_0000, offs)
    host_u.rd(8'he7, rd);
    `CHK("staged", 8'h17, rd)
    host_u.wr(8'he9, 8'h83);
    `CHK("offset", 24'h83_7717, offs)
    host_u.wr_offset(24'h7c_88e8);
    `CHK("offset", 24'h7c_88e8, offs)
  endtask
  task automatic t_page();
    host_u.wr(8'hff, 8'h01);
    `CHK("page", 2'h1, page)
    host_u.wr(8'h17, 8'h33);
    `CHK("hs_div", 11'h7fe, hs)
    host_u.rd(8'h17, rd);
    `CHK("page1_rd", 8'h00, rd)
    host_u.rd(8'hff, rd);
    `CHK("page_rd", 8'h01, rd)
    host_u.wr(8'hff, 8'h00);
    host_u.rd(8'h17, rd);
    `CHK("page0_rd", 8'hfe, rd)
  endtask
  task automatic t_soft_reset();
    host_u.wr(8'h07, 8'h88);
    `CHK("soft_cnt", 1, n_soft)
    `CHK("cal_cnt", 1, n_cal)
    `CHK("hs_div", 11'h054, hs)
    `CHK("offset", 24'h00_0000, offs)
    `CHK("fb_div", 43'h064_0000_0000, fb)
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (5) @(negedge clk_in);
    t_ident();
    t_dividers();
    t_feedback();
    t_clock_bypass();
    t_fine_offset();
    t_page();
    t_soft_reset();
    `CHK("nak_cnt", 0, host_u.n_nak)
    print_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk_in);
    failures++;
    print_verdict();
  end
endmodule

bind ofcr_regs ofcr_regs_chk chk_u (
  .clk_in, .reset_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .output_clock_enable_out,
  .high_speed_divider_out, .power_of_two_divider_out, .power_of_two_ratio_out, .feedback_divider_ratio_out,
  .calibration_bypass_out, .fine_frequency_offset_out, .page_out, .soft_reset_out, .calibration_start_out);
